// file: hw/port_halt_wake_watchdog.sv
// four-bit port with halt control, pin wake-up and watchdog, behind classic wishbone
`timescale 1ns/1ns
// What this block does
// [R1] halt request stops the program counter and the gated system clock
// [R2] while halted only pin wake or reset returns to normal mode
// [R3] halt loads pc 0x004; after wake pc advances after 64 stable clocks
// [R4] reset beats wake in halt; pc goes to 0x000, then 64 clocks
// [R5] working memory is kept through halt; nothing here clears it
// [R6] enabled pin rising edge in halt wakes, restarts clock, vector 0x004
// [R7] dual-edge option makes both edges wake
// [R8] watchdog times out after 256*256*16 clocks since last clear
// [R9] watchdog cleared on wake, reset, halt entry and software clear
// [R10] any write to the rom data high nibble register clears the watchdog
// [R11] watchdog overflow resets the whole system
// [R12] halt entry clears the watchdog counter
// [R13] direction register: 1 output, 0 input, resets to 0000
// [R14] data writes load latch; reads give latch for outputs, pin for inputs
// [R15] pull-downs off on output pins, else per option
// [R16] substitution option turns mid pull-down selection into weak pull-down
// [R17] carrier option: pin 3 output emits 38 kHz when data bit 3 set
// [R18] pin 3 output is forced low during halt
// [R19] rc option enables pin 0 schmitt wake buffer after power-on reset
// [R20] amplifier option disables both pull-downs on pin 0
// [R21] watchdog enable is a fixed option, not a register
// [R22] wake edges captured without the stopped clock, released after restart
module port_halt_wake_watchdog #(
    parameter int WDOG_LIMIT = port_hww_pkg::WDOG_CYCLES,
    parameter bit WATCHDOG_ENABLE_OPTION = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] port_pins_i,
    output logic [3:0] port_pins_o,
    output logic [3:0] port_pins_oe_n_o,
    output port_hww_pkg::analog_ctl_type analog_o,
    output logic sys_clk_en_o,
    output logic [11:0] pc_o,
    output logic system_reset_o
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr;
    logic [5:0] idx;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[7:2];

    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0] direction_r;
    logic [3:0] data_r;
    logic [31:0] control_r;
    port_hww_pkg::options_type opt;
    logic wdog_ovf;
    logic any_rst;

    assign any_rst = rst_i | wdog_ovf; // [R11]
    assign opt.dual_edge = control_r[port_hww_pkg::CTL_DUAL_EDGE_BIT];
    assign opt.weak_subst = control_r[port_hww_pkg::CTL_SUBST_BIT];
    assign opt.carrier = control_r[port_hww_pkg::CTL_CARRIER_BIT];
    assign opt.rc_wake = control_r[port_hww_pkg::CTL_RC_BIT];
    assign opt.amp_wake = control_r[port_hww_pkg::CTL_AMP_BIT];
    assign opt.wake_en = control_r[port_hww_pkg::CTL_WAKE_EN_POS +: 4];
    assign opt.pd_mid = control_r[port_hww_pkg::CTL_PD_MID_POS +: 4];
    assign opt.pd_high = control_r[port_hww_pkg::CTL_PD_HIGH_POS +: 4];

    // ------------------------------------------------------------
    // halt state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_HALT = 3'b010,
        ST_SETTLE = 3'b100
    } mode_type;
    mode_type mode_r;
    logic [6:0] settle_cnt_r;
    logic halt_cmd;
    logic wake_seen;

    assign halt_cmd = wr & hit(idx, port_hww_pkg::OFS_CONTROL)
        & wb_dat_i[port_hww_pkg::CTL_HALT_BIT] & (mode_r == ST_RUN);

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            direction_r <= port_hww_pkg::DIRECTION_RESET; // [R13]
        end else if (wr & hit(idx, port_hww_pkg::OFS_PORT_DIRECTION) & (mode_r == ST_RUN)) begin
            direction_r <= wb_dat_i[3:0]; // [R2]
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            data_r <= port_hww_pkg::DATA_RESET;
        end else if (wr & hit(idx, port_hww_pkg::OFS_PORT_DATA) & (mode_r == ST_RUN)) begin
            data_r <= wb_dat_i[3:0]; // [R14]
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            control_r <= 32'h0000_0000;
        end else if (wr & hit(idx, port_hww_pkg::OFS_OPTIONS) & (mode_r == ST_RUN)) begin
            control_r <= {12'h000, wb_dat_i[19:8], 2'b00, wb_dat_i[5:1], 1'b0}; // [R2]
        end
    end

    // edges are captured as a three-stage sampled change; in silicon the same
    // capture sits on an asynchronous latch since the core clock is gated off
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_s3_r;
    logic [3:0] pin_stable_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
        end else begin
            pin_s1_r <= port_pins_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_stable_r <= 4'h0;
        end else begin
            pin_stable_r <= (pin_s2_r & pin_s3_r) | (pin_stable_r & (pin_s2_r | pin_s3_r));
        end
    end
    logic [3:0] pin_new;
    logic [3:0] rise;
    logic [3:0] fall;
    assign pin_new = (pin_s2_r & pin_s3_r) | (pin_stable_r & (pin_s2_r | pin_s3_r));
    assign rise = pin_new & ~pin_stable_r;
    assign fall = ~pin_new & pin_stable_r;
    assign wake_seen = |(opt.wake_en & ~direction_r & (rise | (fall & {4{opt.dual_edge}}))); // [R6] [R7]

    logic wake_req_r;
    always_ff @(posedge clk_i) begin
        if (any_rst | (mode_r != ST_HALT)) begin
            wake_req_r <= 1'b0;
        end else if (wake_seen) begin
            wake_req_r <= 1'b1; // [R22]
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            mode_r <= ST_SETTLE; // [R4]
            settle_cnt_r <= 7'd0;
        end else begin
            unique case (mode_r)
                ST_RUN: begin
                    if (halt_cmd) begin
                        mode_r <= ST_HALT; // [R1]
                    end
                end
                ST_HALT: begin
                    if (wake_req_r) begin
                        mode_r <= ST_SETTLE; // [R2] [R22]
                        settle_cnt_r <= 7'd0;
                    end
                end
                ST_SETTLE: begin
                    if (settle_cnt_r == 7'(port_hww_pkg::SETTLE_CYCLES - 1)) begin
                        mode_r <= ST_RUN; // [R3]
                    end else begin
                        settle_cnt_r <= settle_cnt_r + 7'd1;
                    end
                end
                default: mode_r <= ST_SETTLE;
            endcase
        end
    end

    // program counter view: vector loaded at once, advance after settling
    logic [11:0] pc_r;
    logic pc_from_reset_r;
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            pc_r <= port_hww_pkg::PC_RESET_VECTOR; // [R4]
            pc_from_reset_r <= 1'b1;
        end else if (halt_cmd) begin
            pc_r <= port_hww_pkg::PC_WAKE_VECTOR; // [R3] [R6]
            pc_from_reset_r <= 1'b0;
        end else if (mode_r == ST_SETTLE && settle_cnt_r == 7'(port_hww_pkg::SETTLE_CYCLES - 1)) begin
            pc_r <= pc_r + 12'h001; // [R3] [R4]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_clk_en_o <= 1'b1;
        end else begin
            sys_clk_en_o <= (mode_r != ST_HALT) & ~halt_cmd; // [R1] [R5]
        end
    end
    assign pc_o = pc_r;

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    logic [23:0] wdog_cnt_r;
    logic wdog_clr;
    logic wdog_flag_r;
    assign wdog_clr = halt_cmd | (wake_req_r & (mode_r == ST_HALT)) // [R9] [R12]
        | (req & wb_we_i & hit(idx, port_hww_pkg::OFS_ROM_DATA_HIGH_NIBBLE)); // [R10]
    assign wdog_ovf = WATCHDOG_ENABLE_OPTION // [R21]
        & (wdog_cnt_r == 24'(WDOG_LIMIT - 1)) & ~wdog_clr;
    always_ff @(posedge clk_i) begin
        if (any_rst | wdog_clr | ~WATCHDOG_ENABLE_OPTION) begin
            wdog_cnt_r <= 24'h000000; // [R9]
        end else if (mode_r != ST_HALT) begin
            wdog_cnt_r <= wdog_cnt_r + 24'h000001; // [R8]
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            system_reset_o <= 1'b0;
            wdog_flag_r <= 1'b0;
        end else begin
            system_reset_o <= wdog_ovf; // [R11]
            if (wdog_ovf) begin
                wdog_flag_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // carrier divider and pins
    // ------------------------------------------------------------
    logic [11:0] car_cnt_r;
    logic car_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            car_cnt_r <= 12'h000;
            car_r <= 1'b0;
        end else if (car_cnt_r == 12'(port_hww_pkg::CARRIER_HALF_CYCLES - 1)) begin
            car_cnt_r <= 12'h000;
            car_r <= ~car_r;
        end else begin
            car_cnt_r <= car_cnt_r + 12'h001;
        end
    end

    logic [3:0] pin_drive;
    logic halted;
    assign halted = (mode_r == ST_HALT);
    always_comb begin
        pin_drive = data_r;
        if (opt.carrier) begin
            pin_drive[3] = data_r[3] & car_r; // [R17]
        end
        if (halted) begin
            pin_drive[3] = 1'b0; // [R18]
        end
    end

    logic [3:0] pd_sel_mid;
    always_comb begin
        pd_sel_mid = opt.pd_mid & ~direction_r; // [R15]
        if (opt.amp_wake) begin
            pd_sel_mid[0] = 1'b0; // [R20]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_pins_o <= 4'h0;
            port_pins_oe_n_o <= 4'hF;
            analog_o <= '0;
        end else begin
            port_pins_o <= pin_drive;
            port_pins_oe_n_o <= ~direction_r; // [R13]
            analog_o.pd_mid_on <= pd_sel_mid & {4{~opt.weak_subst}}; // [R16]
            analog_o.pd_weak_on <= pd_sel_mid & {4{opt.weak_subst}}; // [R16]
            analog_o.pd_high_on <= opt.pd_high & ~direction_r & {3'b111, ~opt.amp_wake}; // [R15] [R20]
            analog_o.rc_schmitt_on <= opt.rc_wake; // [R19]
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0000_0000;
        unique case (idx)
            port_hww_pkg::OFS_PORT_DIRECTION: rd[3:0] = direction_r;
            port_hww_pkg::OFS_PORT_DATA: rd[3:0] = (data_r & direction_r)
                | (pin_stable_r & ~direction_r); // [R14]
            port_hww_pkg::OFS_OPTIONS: rd = control_r;
            port_hww_pkg::OFS_STATUS: rd = {16'h0000, pc_r, 1'b0, wdog_flag_r,
                (mode_r == ST_SETTLE), halted};
            default: rd = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd;
            end
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DIR_RESET: assert property (@(posedge clk_i) rst_i |=> direction_r == 4'h0) // [R13]
        else $error("direction not cleared by reset");
    AST_HALT_PC: assert property (@(posedge clk_i) disable iff (rst_i) halt_cmd |=> pc_r == 12'h004) // [R3]
        else $error("pc not at wake vector after halt");
    AST_HALT_CLK: assert property (@(posedge clk_i) disable iff (rst_i) halt_cmd |=> ##1 !sys_clk_en_o) // [R1]
        else $error("clock not stopped in halt");
    // independent count of settling cycles, so the check does not lean on settle_cnt_r
    logic [7:0] chk_settle_len_r;
    always_ff @(posedge clk_i) begin
        if (any_rst | (mode_r != ST_SETTLE)) begin
            chk_settle_len_r <= 8'h00;
        end else begin
            chk_settle_len_r <= chk_settle_len_r + 8'h01;
        end
    end
    AST_WAKE_SETTLE: assert property (@(posedge clk_i) disable iff (any_rst)
        (mode_r == ST_HALT && wake_req_r) |=> mode_r == ST_SETTLE) // [R3]
        else $error("wake did not enter settling");
    AST_SETTLE_HOLD: assert property (@(posedge clk_i) disable iff (any_rst)
        (mode_r == ST_SETTLE && chk_settle_len_r != 8'(port_hww_pkg::SETTLE_CYCLES - 1))
        |=> mode_r == ST_SETTLE) // [R3]
        else $error("settling ended early");
    AST_SETTLE_64: assert property (@(posedge clk_i) disable iff (any_rst)
        (mode_r == ST_SETTLE && chk_settle_len_r == 8'(port_hww_pkg::SETTLE_CYCLES - 1))
        |=> mode_r == ST_RUN) // [R3]
        else $error("settle length wrong");
    AST_WAKE_ONLY: assert property (@(posedge clk_i) disable iff (any_rst)
        (mode_r == ST_HALT && !wake_req_r) |=> mode_r == ST_HALT) // [R2]
        else $error("left halt without wake");
    AST_WDOG_CLR: assert property (@(posedge clk_i) disable iff (rst_i) wdog_clr |=> wdog_cnt_r == 24'h0) // [R10]
        else $error("watchdog not cleared");
    AST_PIN3_HALT: assert property (@(posedge clk_i) disable iff (rst_i) halted |=> !port_pins_o[3]) // [R18]
        else $error("pin 3 driven high in halt");
    AST_RST_PC: assert property (@(posedge clk_i) $rose(system_reset_o) |-> pc_r == 12'h000) // [R11]
        else $error("watchdog reset did not reach pc");
    AST_PD_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 ((analog_o.pd_mid_on | analog_o.pd_weak_on | analog_o.pd_high_on)
        & $past(direction_r)) == 4'h0) // [R15]
        else $error("pull-down on an output pin");
    COV_HALT: cover property (@(posedge clk_i) halt_cmd);
    COV_WAKE: cover property (@(posedge clk_i) mode_r == ST_HALT ##1 mode_r == ST_SETTLE);
    COV_WDOG: cover property (@(posedge clk_i) wdog_ovf);
    COV_RST_IN_HALT: cover property (@(posedge clk_i) halted && rst_i);
    COV_CARRIER: cover property (@(posedge clk_i) opt.carrier && direction_r[3] && data_r[3]);
endmodule

// file: hw/port_hww_pkg.sv
// package: register map, option layout, timing counts and carriers for the port block
package port_hww_pkg;
    // register offsets, word index on the bus (byte address = 4 * index)
    localparam logic [5:0] OFS_PORT_DIRECTION = 6'h02;
    localparam logic [5:0] OFS_PORT_DATA = 6'h03;
    localparam logic [5:0] OFS_ROM_DATA_HIGH_NIBBLE = 6'h1D;
    localparam logic [5:0] OFS_CONTROL = 6'h20;
    localparam logic [5:0] OFS_STATUS = 6'h21;
    localparam logic [5:0] OFS_OPTIONS = 6'h22;
    // control register fields
    localparam int CTL_HALT_BIT = 0;
    localparam int CTL_DUAL_EDGE_BIT = 1;
    localparam int CTL_SUBST_BIT = 2;
    localparam int CTL_CARRIER_BIT = 3;
    localparam int CTL_RC_BIT = 4;
    localparam int CTL_AMP_BIT = 5;
    localparam int CTL_WAKE_EN_POS = 8;
    localparam int CTL_PD_MID_POS = 12;
    localparam int CTL_PD_HIGH_POS = 16;
    // status register fields
    localparam int STS_HALTED_BIT = 0;
    localparam int STS_SETTLING_BIT = 1;
    localparam int STS_WDOG_RST_BIT = 2;
    localparam int STS_PC_POS = 4;
    // reset values
    localparam logic [3:0] DIRECTION_RESET = 4'h0;
    localparam logic [3:0] DATA_RESET = 4'h0;
    localparam logic [11:0] PC_RESET_VECTOR = 12'h000;
    localparam logic [11:0] PC_WAKE_VECTOR = 12'h004;
    // timing
    localparam int CLK_HZ = 125000000;
    localparam int SETTLE_CYCLES = 64;
    localparam int WDOG_CYCLES = 256 * 256 * 16;
    localparam int CARRIER_HZ = 38000;
    localparam int CARRIER_HALF_CYCLES = CLK_HZ / (2 * CARRIER_HZ);

    typedef struct packed {
        logic dual_edge;
        logic weak_subst;
        logic carrier;
        logic rc_wake;
        logic amp_wake;
        logic [3:0] wake_en;
        logic [3:0] pd_mid;
        logic [3:0] pd_high;
    } options_type;

    typedef struct packed {
        logic [3:0] pd_mid_on;
        logic [3:0] pd_weak_on;
        logic [3:0] pd_high_on;
        logic rc_schmitt_on;
    } analog_ctl_type;
endpackage

// file: sim/pin_partner.sv
// partner model: buttons, pull-downs and floating pads on the four port pins
`timescale 1ns/1ns
module pin_partner (
    input wire logic clk_i,
    input wire logic [3:0] drive_i,
    input wire logic [3:0] oe_n_i,
    input wire port_hww_pkg::analog_ctl_type analog_i,
    input wire logic [3:0] btn_en_i,
    input wire logic [3:0] btn_val_i,
    output logic [3:0] pins_o
);
    logic float_r = 1'b0;
    logic [3:0] pd_any;

    // undriven pad with no pull-down: toggles so no settled value can pass
    always @(posedge clk_i) begin
        float_r <= ~float_r;
    end

    assign pd_any = analog_i.pd_mid_on | analog_i.pd_weak_on | analog_i.pd_high_on;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!oe_n_i[i]) begin
                pins_o[i] = drive_i[i];
            end else if (btn_en_i[i]) begin
                pins_o[i] = btn_val_i[i];
            end else if (pd_any[i]) begin
                pins_o[i] = 1'b0;
            end else begin
                pins_o[i] = float_r;
            end
        end
    end
endmodule

// file: sim/testbench.sv
// self-checking testbench for the port, halt, wake and watchdog block
`timescale 1ns/1ns
module testbench;
    localparam int WDL = 6000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rd;
    logic [3:0] sel = 4'h0, pins_in, pins_out, oe_n, btn_en = 4'h0, btn_val = 4'h0;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic [31:0] dat_o;
    logic ack, clk_en, sys_rst;
    logic [11:0] pc;
    port_hww_pkg::analog_ctl_type ana;
    int n_fail = 0, comparisons = 0, n, t, pulses = 0;

    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (sys_rst === 1'b1) pulses <= pulses + 1;

    port_halt_wake_watchdog #(.WDOG_LIMIT(WDL), .WATCHDOG_ENABLE_OPTION(1'b1))
        port_halt_wake_watchdog_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .port_pins_i(pins_in), .port_pins_o(pins_out),
        .port_pins_oe_n_o(oe_n), .analog_o(ana), .sys_clk_en_o(clk_en), .pc_o(pc),
        .system_reset_o(sys_rst));

    pin_partner pin_partner_inst (.clk_i(clk_i), .drive_i(pins_out), .oe_n_i(oe_n),
        .analog_i(ana), .btn_en_i(btn_en), .btn_val_i(btn_val), .pins_o(pins_in));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // classic single cycle; waits for ack with no assumed latency
    task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        adr <= {24'h0, idx, 2'b00};
        we <= w;
        wdat <= d;
        sel <= 4'hF;
        cyc <= 1'b1;
        stb <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (ack !== 1'b1) n_fail++;
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic settle;
        repeat (70) @(posedge clk_i);
        bus(1'b1, port_hww_pkg::OFS_ROM_DATA_HIGH_NIBBLE, 32'h0);
    endtask

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic port_regs;
        check("pc_after_reset", pc, 32'(port_hww_pkg::PC_RESET_VECTOR));
        settle();
        bus(1'b0, port_hww_pkg::OFS_PORT_DIRECTION, 32'h0);
        check("dir_reset", rd[3:0], 4'h0);
        check("oe_n_reset", oe_n, 4'hF);
        bus(1'b0, 6'h05, 32'h0);
        check("unmapped_read", rd, 32'h0);
        bus(1'b1, port_hww_pkg::OFS_PORT_DIRECTION, 32'hA);
        bus(1'b1, port_hww_pkg::OFS_PORT_DATA, 32'hF);
        btn_en <= 4'h5;
        btn_val <= 4'h1;
        repeat (6) @(posedge clk_i);
        bus(1'b0, port_hww_pkg::OFS_PORT_DATA, 32'h0);
        check("data_mixed_read", rd[3:0], 4'hB);
        check("oe_n_dir", oe_n, 4'h5);
        check("drive_outputs", pins_out & 4'hA, 4'hA);
        bus(1'b1, port_hww_pkg::OFS_OPTIONS, 32'hFF000);
        repeat (3) @(posedge clk_i);
        check("pd_mid_inputs", ana.pd_mid_on, 4'h5);
        check("pd_high_inputs", ana.pd_high_on, 4'h5);
        bus(1'b1, port_hww_pkg::OFS_OPTIONS, 32'hFF000 | 32'h4);
        repeat (3) @(posedge clk_i);
        check("pd_weak_subst", {ana.pd_weak_on, ana.pd_mid_on}, 8'h50);
        bus(1'b1, port_hww_pkg::OFS_OPTIONS, 32'hFF000 | 32'h34);
        repeat (3) @(posedge clk_i);
        check("pd_amp_pin0", {ana.pd_weak_on, ana.pd_high_on}, 8'h44);
        check("rc_schmitt", ana.rc_schmitt_on, 1'b1);
    endtask

    task automatic carrier;
        bus(1'b1, port_hww_pkg::OFS_OPTIONS, 32'h8);
        bus(1'b1, port_hww_pkg::OFS_PORT_DIRECTION, 32'h8);
        bus(1'b1, port_hww_pkg::OFS_PORT_DATA, 32'h0);
        t = 0;
        repeat (100) begin
            @(posedge clk_i);
            if (pins_out[3] !== 1'b0) t++;
        end
        check("carrier_off_low", t, 0);
        bus(1'b1, port_hww_pkg::OFS_PORT_DATA, 32'h8);
        bus(1'b1, port_hww_pkg::OFS_ROM_DATA_HIGH_NIBBLE, 32'h0);
        t = 0;
        n = 0;
        repeat (3 * port_hww_pkg::CARRIER_HALF_CYCLES + 10) begin
            @(posedge clk_i);
            if (pins_out[3] === 1'b1) begin
                t++;
            end else if (t > 0) begin
                n = t;
                t = 0;
            end
        end
        check("carrier_half_period", n, port_hww_pkg::CARRIER_HALF_CYCLES);
        check("no_wdog_reset_fed", pulses, 0);
    endtask

    task automatic halt_and_wake(input logic [31:0] opts, input logic pin_first);
        bus(1'b1, port_hww_pkg::OFS_OPTIONS, opts);
        bus(1'b1, port_hww_pkg::OFS_PORT_DIRECTION, 32'h8);
        bus(1'b1, port_hww_pkg::OFS_PORT_DATA, 32'h8);
        btn_en <= 4'h1;
        btn_val <= {3'b000, pin_first};
        repeat (6) @(posedge clk_i);
        bus(1'b1, port_hww_pkg::OFS_CONTROL, 32'h1);
        repeat (2) @(posedge clk_i);
        check("clk_stopped", clk_en, 1'b0);
        check("pc_halt_vector", pc, 32'(port_hww_pkg::PC_WAKE_VECTOR));
        check("pin3_low_halt", pins_out[3], 1'b0);
    endtask

    task automatic wait_wake(input string name);
        n = 0;
        while (clk_en !== 1'b1 && n < 30) begin
            @(posedge clk_i);
            n++;
        end
        check(name, clk_en, 1'b1);
        n = 0;
        while (pc === 12'h004 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        check("settle_len", (n >= 62 && n <= 68), 1'b1);
        settle();
    endtask

    task automatic halt_tests;
        halt_and_wake(32'h100, 1'b1);
        btn_val <= 4'h0;
        repeat (20) @(posedge clk_i);
        check("falling_no_wake", clk_en, 1'b0);
        btn_val <= 4'h1;
        wait_wake("rise_wakes");
        halt_and_wake(32'h102, 1'b1);
        btn_val <= 4'h0;
        wait_wake("fall_wakes_dual");
        halt_and_wake(32'h0, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("pc_reset_in_halt", pc, 32'(port_hww_pkg::PC_RESET_VECTOR));
        check("clk_running_reset", clk_en, 1'b1);
        settle();
    endtask

    task automatic watchdog;
        bus(1'b1, port_hww_pkg::OFS_PORT_DIRECTION, 32'h3);
        n = 0;
        while (sys_rst !== 1'b1 && n < WDL + 100) begin
            @(posedge clk_i);
            n++;
        end
        check("wdog_span", (n >= WDL - 10 && n <= WDL + 5), 1'b1);
        settle();
        bus(1'b0, port_hww_pkg::OFS_PORT_DIRECTION, 32'h0);
        check("dir_after_wdog", rd[3:0], 4'h0);
        bus(1'b0, port_hww_pkg::OFS_STATUS, 32'h0);
        check("wdog_seen", rd[port_hww_pkg::STS_WDOG_RST_BIT], 1'b1);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        port_regs();
        carrier();
        halt_tests();
        watchdog();
        tally_and_finish();
    end

    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        tally_and_finish();
    end
endmodule
